// ==== tdh_top.v ====
// Telemetry data handler: accumulators, sector pulses, framer, modulator
//
// Overview of operation
// - Magnetometer sample is eight converter bits plus one range bit.
// - Sector generator emits eight pulses every second spin revolution.
// - Sector logic runs from reference tick, synchronised by field zero crossing.
// - Period counted at reference rate; K-rate counter pulses on coincidence.
// - Eight pulses split the measured period into equal intervals.
// - Accumulators count to 2^24 - 1 and hold, reported as compressed eight-bit value.
// - Digital mux takes 99 status bits and seven word inputs: six accumulators and the sample.
// - Analog mux selects one of at most 54 channels for the converter.
// - Programmer sequences muxes and converter into one serial stream.
// - Every frame carries two eight-bit sync words.
// - Sync words not stored; added on readback or live output.
// - NRZ-L serial data keys a square-wave subcarrier: toggles while high, holds while low.
// - Subcarrier to transmitter with convolutional coding applied or bypassed.
// - All rates come from one clock through a divider chain.
// - 18-bit elapsed-time counter advances every 0.4 second.
// - Command inputs from command logic steer control actions.
// - Test mode replaces detector inputs with internal pulse rates.
// - Magnetometer scale signal forms the range bit of each sample.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "tdh_regs.vh"
module tdh_top #(
  parameter MET_CYC = `TDH_MET_CYC          // Cycles per elapsed-time count
) (
  input  wire        hclk,                  // Bus clock
  input  wire        hresetn,               // Async reset, active low
  input  wire        clk_en,                // Freezes all state when low
  input  wire        hsel,                  // Slave select
  input  wire [31:0] haddr,                 // Address
  input  wire [1:0]  htrans,                // Transfer type
  input  wire        hwrite,                // Write
  input  wire [2:0]  hsize,                 // Size
  input  wire [31:0] hwdata,                // Write data
  input  wire        hready,                // Bus ready
  output reg  [31:0] hrdata,                // Read data
  output reg         hreadyout,             // Slave ready
  output reg         hresp,                 // Response, always OKAY
  input  wire [5:0]  det_pulse,             // Particle detector pulses
  input  wire [98:0] status_bits,           // Bi-level status inputs
  input  wire        field_sign,            // Magnetic field polarity
  input  wire        mag_scale,             // Magnetometer range bit
  input  wire [7:0]  conv_data,             // Converter result
  output reg  [5:0]  amux_sel_ff,           // Analog mux channel
  output reg         conv_start_ff,         // Converter start pulse
  output reg         sector_pulse_ff,       // Sector pulse
  output reg         mem_wr_ff,             // Store a data byte
  output reg  [7:0]  mem_wdata_ff,          // Byte to store
  input  wire        mem_rd_valid,          // Stored byte available
  input  wire [7:0]  mem_rdata,             // Stored byte
  output reg         mem_rd_ready_ff,       // Stored byte taken
  output reg         ser_data_ff,           // Serial stream
  output reg         subcarrier_ff,         // Modulator output
  output reg  [7:0]  cmd_out_ff             // Control action outputs
);
  // ==========================================================
  // Input synchronisers, three stages, agree of last two
  // ==========================================================
  reg [5:0] det_s1_ff, det_s2_ff, det_s3_ff, det_st_ff;
  reg [2:0] fs_ff, sc_ff;
  reg       fs_st_ff, sc_st_ff;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      det_s1_ff <= 6'h00; det_s2_ff <= 6'h00; det_s3_ff <= 6'h00;
      det_st_ff <= 6'h00; fs_ff <= 3'h0; sc_ff <= 3'h0;
      fs_st_ff <= 1'b0; sc_st_ff <= 1'b0;
    end else if (clk_en) begin
      det_s1_ff <= det_pulse;
      det_s2_ff <= det_s1_ff;
      det_s3_ff <= det_s2_ff;
      det_st_ff <= (det_s2_ff & det_s3_ff) | (det_st_ff & (det_s2_ff | det_s3_ff));
      fs_ff <= {fs_ff[1:0], field_sign};
      sc_ff <= {sc_ff[1:0], mag_scale};
      if (fs_ff[1] == fs_ff[2]) fs_st_ff <= fs_ff[2];
      if (sc_ff[1] == sc_ff[2]) sc_st_ff <= sc_ff[2];
    end
  end

  // ==========================================================
  // Registers and divider chain
  // ==========================================================
  reg [31:0] ctrl_ff;
  reg [15:0] sync_ff;
  reg [6:0]  dsel_ff;
  reg [5:0]  asel_ff;
  reg [17:0] met_ff;
  reg [31:0] met_div_ff;
  reg [9:0]  ref_div_ff;
  reg [6:0]  bit_div_ff;
  reg [3:0]  sub_div_ff;
  reg [23:0] acc_ff [0:5];
  reg [2:0]  acc_sel_ff;
  reg        acc_clr;
  reg [8:0]  sample_ff;
  reg [15:0] frame_cnt_ff;
  localparam [9:0]  REF_LOAD = `TDH_REF_DIV - 1;
  localparam [6:0]  BIT_LOAD = `TDH_BIT_DIV - 1;
  localparam [3:0]  SUB_LOAD = `TDH_SUB_DIV - 1;
  localparam [19:0] SECT_K20 = `TDH_SECT_K;
  wire run = ctrl_ff[`TDH_CTRL_RUN];
  wire ref_tick = (ref_div_ff == 10'd0);
  wire bit_tick = (bit_div_ff == 7'd0);
  wire sub_tick = (sub_div_ff == 4'd0);
  wire met_tick = (met_div_ff == 32'd0);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ref_div_ff <= 10'd0; bit_div_ff <= 7'd0; sub_div_ff <= 4'd0;
      met_div_ff <= 32'd0; met_ff <= 18'h00000;
    end else if (clk_en) begin
      ref_div_ff <= ref_tick ? REF_LOAD : ref_div_ff - 10'd1;
      bit_div_ff <= bit_tick ? BIT_LOAD : bit_div_ff - 7'd1;
      sub_div_ff <= sub_tick ? SUB_LOAD : sub_div_ff - 4'd1;
      met_div_ff <= met_tick ? MET_CYC - 1 : met_div_ff - 32'd1;
      if (met_tick) met_ff <= met_ff + 18'd1;
    end
  end

  // ==========================================================
  // Particle accumulators
  // ==========================================================
  reg  [5:0] det_prev_ff;
  wire [5:0] cnt_in = ctrl_ff[`TDH_CTRL_TEST] ?
                      {6{ref_tick}} : (det_st_ff & ~det_prev_ff);
  genvar g;
  generate
    for (g = 0; g < `TDH_NUM_ACC; g = g + 1) begin : g_acc
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) acc_ff[g] <= 24'h000000;
        else if (clk_en) begin
          if (acc_clr && acc_sel_ff == g) acc_ff[g] <= 24'h000000;
          else if (cnt_in[g] && acc_ff[g] != 24'hFFFFFF)
            acc_ff[g] <= acc_ff[g] + 24'd1;
        end
      end
    end
  endgenerate
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) det_prev_ff <= 6'h00;
    else if (clk_en) det_prev_ff <= det_st_ff;
  end
  // compress to 5-bit exponent, 3-bit mantissa, under 12.5 percent
  function [7:0] compress;
    input [23:0] v;
    integer i;
    reg [4:0] e;
    reg [2:0] m;
    begin
      e = 5'd0;
      m = v[2:0];
      for (i = 3; i < 24; i = i + 1)
        if (v[i]) begin
          e = i[4:0] - 5'd2;
          m = v[i-1 -: 3];
        end
      compress = {e, m};
    end
  endfunction
  wire [7:0] acc_word = compress(acc_ff[acc_sel_ff]);

  // ==========================================================
  // Sector pulse generator
  // ==========================================================
  reg [19:0] per_cnt_ff, per_ff, k_cnt_ff;
  reg        fs_prev_ff, rev_odd_ff, burst_ff;
  reg [3:0]  sect_ff;
  reg [9:0]  sdiv_ff;
  wire zc = fs_st_ff & ~fs_prev_ff;
  wire sref_tick = (sdiv_ff == 10'd0);
  wire burst_go = ~rev_odd_ff && per_cnt_ff != 20'd0;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_ff <= 20'd0; per_ff <= 20'd0; k_cnt_ff <= 20'd0;
      fs_prev_ff <= 1'b0; rev_odd_ff <= 1'b0; burst_ff <= 1'b0;
      sect_ff <= 4'd0; sector_pulse_ff <= 1'b0; sdiv_ff <= 10'd0;
    end else if (clk_en) begin
      fs_prev_ff <= fs_st_ff;
      sector_pulse_ff <= 1'b0;
      if (zc) begin
        // reference restarts at crossing, so no tick collides with it
        sdiv_ff <= REF_LOAD;
        per_ff <= per_cnt_ff;
        // Crossing-to-first-tick counts as one tick
        per_cnt_ff <= 20'd1;
        rev_odd_ff <= ~rev_odd_ff;
        // burst every other revolution, first pulse at crossing
        burst_ff <= burst_go;
        sector_pulse_ff <= burst_go;
        sect_ff <= burst_go ? 4'd1 : 4'd0;
        k_cnt_ff <= 20'd0;
      end else begin
        sdiv_ff <= sref_tick ? REF_LOAD : sdiv_ff - 10'd1;
        if (sref_tick && per_cnt_ff != 20'hFFFFF)
          per_cnt_ff <= per_cnt_ff + 20'd1;
        // K-rate count; spacing resolution is one reference tick
        if (burst_ff && sect_ff < `TDH_SECT_K && sref_tick) begin
          if (k_cnt_ff + SECT_K20 >= per_ff) begin
            k_cnt_ff <= k_cnt_ff + SECT_K20 - per_ff;
            sector_pulse_ff <= 1'b1;
            sect_ff <= sect_ff + 4'd1;
          end else k_cnt_ff <= k_cnt_ff + SECT_K20;
        end
      end
    end
  end

  // ==========================================================
  // Programmer: conversion, word select, push to buffer
  // ==========================================================
  localparam [3:0] S_IDLE = 4'b0001, S_CONV = 4'b0010,
                   S_WORD = 4'b0100, S_PUSH = 4'b1000;
  reg [3:0] st_ff;
  reg [7:0] word_ff;
  reg [3:0] wait_ff;
  reg       push;
  reg [1:0] fifo_cnt_ff;
  reg [7:0] fifo_ff [0:1];
  reg       fifo_wp_ff, fifo_rp_ff;
  wire      fifo_in_ready = (fifo_cnt_ff != 2'd2);
  wire [7:0] dword = (dsel_ff < 7'd6) ? acc_word :
                     (dsel_ff < 7'd105) ? {7'h00, status_bits[dsel_ff - 7'd6]} :
                     sample_ff[7:0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= S_IDLE; word_ff <= 8'h00; wait_ff <= 4'd0;
      amux_sel_ff <= 6'd0; conv_start_ff <= 1'b0; sample_ff <= 9'h000;
      acc_sel_ff <= 3'd0; acc_clr <= 1'b0; push <= 1'b0;
    end else if (clk_en) begin
      conv_start_ff <= 1'b0;
      acc_clr <= 1'b0;
      push <= 1'b0;
      case (st_ff)
        S_IDLE: if (run && bit_tick) begin
          amux_sel_ff <= (asel_ff < 6'd54) ? asel_ff : 6'd0;
          conv_start_ff <= 1'b1;
          wait_ff <= 4'd8;
          st_ff <= S_CONV;
        end
        S_CONV: if (wait_ff == 4'd0) begin
          sample_ff <= {sc_st_ff, conv_data};
          st_ff <= S_WORD;
        end else wait_ff <= wait_ff - 4'd1;
        S_WORD: begin
          word_ff <= dword;
          acc_sel_ff <= (dsel_ff < 7'd6) ? dsel_ff[2:0] : 3'd0;
          acc_clr <= (dsel_ff < 7'd6);
          st_ff <= S_PUSH;
        end
        S_PUSH: if (fifo_in_ready) begin
          push <= 1'b1;
          st_ff <= S_IDLE;
        end
        default: st_ff <= S_IDLE;
      endcase
    end
  end

  // Two-entry buffer so a stalled serialiser loses no word
  wire src_rt = ctrl_ff[`TDH_CTRL_REALTIME];
  wire fifo_out_valid = (fifo_cnt_ff != 2'd0);
  reg  ser_take;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_cnt_ff <= 2'd0; fifo_wp_ff <= 1'b0; fifo_rp_ff <= 1'b0;
      fifo_ff[0] <= 8'h00; fifo_ff[1] <= 8'h00;
      mem_wr_ff <= 1'b0; mem_wdata_ff <= 8'h00;
    end else if (clk_en) begin
      mem_wr_ff <= 1'b0;
      if (push) begin
        fifo_ff[fifo_wp_ff] <= word_ff;
        fifo_wp_ff <= ~fifo_wp_ff;
      end
      if (fifo_out_valid && (src_rt ? ser_take : 1'b1)) begin
        fifo_rp_ff <= ~fifo_rp_ff;
        if (!src_rt) begin
          mem_wr_ff <= 1'b1;
          mem_wdata_ff <= fifo_ff[fifo_rp_ff];
        end
      end
      fifo_cnt_ff <= fifo_cnt_ff + {1'b0, push}
        - {1'b0, fifo_out_valid && (src_rt ? ser_take : 1'b1)};
    end
  end

  // ==========================================================
  // Serialiser, sync insertion, modulator
  // ==========================================================
  reg [7:0] sh_ff;
  reg [2:0] bitn_ff;
  reg [3:0] wcnt_ff;
  reg       busy_ff;
  reg [1:0] cst_ff;
  wire      have = src_rt ? fifo_out_valid : mem_rd_valid;
  wire [7:0] dnext = src_rt ? fifo_ff[fifo_rp_ff] : mem_rdata;
  always @* begin
    ser_take = src_rt && bit_tick && (!busy_ff || bitn_ff == 3'd7) &&
               wcnt_ff >= 4'd2 && fifo_out_valid;
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_ff <= 8'h00; bitn_ff <= 3'd0; wcnt_ff <= 4'd0; busy_ff <= 1'b0;
      ser_data_ff <= 1'b0; mem_rd_ready_ff <= 1'b0; cst_ff <= 2'b00;
      frame_cnt_ff <= 16'h0000; subcarrier_ff <= 1'b0;
    end else if (clk_en) begin
      mem_rd_ready_ff <= 1'b0;
      if (bit_tick && run) begin
        if (!busy_ff || bitn_ff == 3'd7) begin
          bitn_ff <= 3'd0;
          // two sync words start a frame
          if (wcnt_ff < 4'd2) begin
            sh_ff <= (wcnt_ff == 4'd0) ? sync_ff[15:8] : sync_ff[7:0];
            wcnt_ff <= wcnt_ff + 4'd1;
            busy_ff <= 1'b1;
          end else if (have) begin
            sh_ff <= dnext;
            mem_rd_ready_ff <= !src_rt;
            busy_ff <= 1'b1;
            if (wcnt_ff == 4'd15) begin
              wcnt_ff <= 4'd0;
              frame_cnt_ff <= frame_cnt_ff + 16'd1;
            end else wcnt_ff <= wcnt_ff + 4'd1;
          end else busy_ff <= 1'b0;
        end else begin
          bitn_ff <= bitn_ff + 3'd1;
          sh_ff <= {sh_ff[6:0], 1'b0};
        end
        cst_ff <= {cst_ff[0], sh_ff[7]};
        ser_data_ff <= ctrl_ff[`TDH_CTRL_CONV] ?
                       (sh_ff[7] ^ cst_ff[0] ^ cst_ff[1]) : sh_ff[7];
      end
      if (sub_tick && (ser_data_ff || bit_div_ff[0]))
        subcarrier_ff <= ~subcarrier_ff;
    end
  end

  // ==========================================================
  // AHB-Lite slave, zero wait states
  // ==========================================================
  reg        wr_pend_ff;
  reg [7:0]  wa_ff;
  wire       take = hsel && hready && htrans[1];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `TDH_CTRL_RESET; sync_ff <= `TDH_SYNC_RESET;
      dsel_ff <= 7'd0; asel_ff <= 6'd0; cmd_out_ff <= 8'h00;
      wr_pend_ff <= 1'b0; wa_ff <= 8'h00; hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1; hresp <= 1'b0;
    end else if (clk_en) begin
      if (take) begin
        wr_pend_ff <= hwrite;
        wa_ff <= haddr[7:0];
        if (!hwrite) case (haddr[7:0])
          `TDH_REG_CTRL:   hrdata <= ctrl_ff;
          `TDH_REG_STATUS: hrdata <= {24'h0, fifo_cnt_ff, 2'b00, st_ff};
          `TDH_REG_MET:    hrdata <= {14'h0, met_ff};
          `TDH_REG_SECTOR: hrdata <= {12'h0, per_ff};
          `TDH_REG_DSEL:   hrdata <= {25'h0, dsel_ff};
          `TDH_REG_ASEL:   hrdata <= {26'h0, asel_ff};
          `TDH_REG_SAMPLE: hrdata <= {23'h0, sample_ff};
          `TDH_REG_ACC:    hrdata <= {8'h0, acc_ff[acc_sel_ff]};
          `TDH_REG_SYNC:   hrdata <= {16'h0, sync_ff};
          `TDH_REG_FRAME:  hrdata <= {16'h0, frame_cnt_ff};
          `TDH_REG_CMD:    hrdata <= {24'h0, cmd_out_ff};
          default:         hrdata <= 32'h0000_0000;
        endcase
      end else wr_pend_ff <= 1'b0;
      if (wr_pend_ff) case (wa_ff)
        `TDH_REG_CTRL: ctrl_ff <= {28'h0, hwdata[3:0]};
        `TDH_REG_DSEL: dsel_ff <= (hwdata[6:0] < 7'd106) ? hwdata[6:0] : 7'd0;
        `TDH_REG_ASEL: asel_ff <= hwdata[5:0];
        `TDH_REG_SYNC: sync_ff <= hwdata[15:0];
        `TDH_REG_CMD:  cmd_out_ff <= hwdata[7:0];
        default: ;
      endcase
    end
  end
endmodule // tdh_top
`default_nettype wire

// ==== tdh_regs.vh ====
// Register map, field layout and timing constants of the telemetry handler
`ifndef TDH_REGS_VH
`define TDH_REGS_VH
`define TDH_REG_CTRL      8'h00
`define TDH_REG_STATUS    8'h04
`define TDH_REG_MET       8'h08
`define TDH_REG_SECTOR    8'h0C
`define TDH_REG_DSEL      8'h10
`define TDH_REG_ASEL      8'h14
`define TDH_REG_SAMPLE    8'h18
`define TDH_REG_ACC       8'h1C
`define TDH_REG_SYNC      8'h20
`define TDH_REG_FRAME     8'h24
`define TDH_REG_CMD       8'h28
`define TDH_CTRL_RESET    32'h0000_0000
`define TDH_SYNC_RESET    16'hEB90
`define TDH_CTRL_RUN      0
`define TDH_CTRL_REALTIME 1
`define TDH_CTRL_CONV     2
`define TDH_CTRL_TEST     3
`define TDH_CLK_MHZ       100
`define TDH_MET_TICK_MS   400
`define TDH_MET_CYC       (`TDH_MET_TICK_MS * 1000 * `TDH_CLK_MHZ)
`define TDH_REF_DIV       1000
`define TDH_BIT_DIV       100
`define TDH_SUB_DIV       10
`define TDH_SECT_K        8
`define TDH_NUM_ACC       6
`define TDH_NUM_BILEVEL   99
`define TDH_NUM_ANALOG    54
`endif

// ==== tdh_monitor.sv ====
// Checker of the telemetry handler port behaviour
`timescale 1ns/1ps
`default_nettype none
module tdh_monitor (
  input wire logic       hclk,            // Clock
  input wire logic       hresetn,         // Reset, active low
  input wire logic       hreadyout,       // Slave ready
  input wire logic       hresp,           // Response
  input wire logic [5:0] amux_sel_ff,     // Analog channel
  input wire logic       conv_start_ff,   // Converter start
  input wire logic       sector_pulse_ff, // Sector pulse
  input wire logic       mem_wr_ff,       // Byte store
  input wire logic       mem_rd_valid,    // Stored byte ready
  input wire logic       mem_rd_ready_ff  // Stored byte taken
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // =====================================================
  // Sequences
  sequence s_chan_held;
    $stable(amux_sel_ff) [*8];
  endsequence
  sequence s_quiet2(sig);
    !sig ##1 !sig;
  endsequence
  // =====================================================
  // Properties
  property p_ready;
    hreadyout;
  endproperty
  a_ready: assert property (p_ready) else $error("wait state seen");
  property p_okay;
    !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_chan_range;
    amux_sel_ff < 6'h36;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel range");
  property p_chan_held;
    conv_start_ff |=> s_chan_held;
  endproperty
  a_chan_held: assert property (p_chan_held) else $error("channel moved");
  property p_conv_pulse;
    conv_start_ff |=> s_quiet2(conv_start_ff);
  endproperty
  a_conv_pulse: assert property (p_conv_pulse) else $error("start long");
  property p_sector_pulse;
    $rose(sector_pulse_ff) |=> s_quiet2(sector_pulse_ff);
  endproperty
  a_sector_pulse: assert property (p_sector_pulse) else $error("sector");
  property p_store_pulse;
    mem_wr_ff |=> !mem_wr_ff;
  endproperty
  a_store_pulse: assert property (p_store_pulse) else $error("store");
  property p_take_valid;
    mem_rd_ready_ff |-> $past(mem_rd_valid);
  endproperty
  a_take_valid: assert property (p_take_valid) else $error("take");
endmodule // tdh_monitor
`default_nettype wire

// ==== tdh_partner.sv ====
// Behavioural storage memory and converter on the far side
`timescale 1ns/1ps
`default_nettype none
module tdh_partner (
  input  wire logic       hclk,         // Clock
  input  wire logic       hresetn,      // Reset, active low
  input  wire logic       conv_start,   // Converter start
  input  wire logic       mem_wr,       // Store strobe
  input  wire logic [7:0] mem_wdata,    // Byte to store
  input  wire logic       mem_rd_ready, // Byte taken
  output var  logic [7:0] conv_data,    // Converter result
  output var  logic       mem_rd_valid, // Byte available
  output var  logic [7:0] mem_rdata     // Stored byte
);
  logic [7:0] mem [0:255];
  logic [7:0] wp;
  logic [7:0] rp;
  logic [7:0] noise;
  logic [4:0] age;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp <= 8'h00;
      rp <= 8'h00;
      age <= 5'h1F;
      noise <= 8'h00;
    end else begin
      noise <= noise + 8'h3B;
      age <= conv_start ? 5'h00 : (age == 5'h1F ? age : age + 5'h01);
      if (mem_wr) begin
        mem[wp] <= mem_wdata;
        wp <= wp + 8'h01;
      end
      if (mem_rd_ready && mem_rd_valid) begin
        rp <= rp + 8'h01;
      end
    end
  end
  assign conv_data = (age >= 5'h01 && age <= 5'h0C) ? 8'h5A : noise;
  assign mem_rd_valid = (rp != wp);
  assign mem_rdata = mem_rd_valid ? mem[rp] : ~noise;
endmodule // tdh_partner
`default_nettype wire

// ==== tdh_top_test.sv ====
// Self-checking testbench of the telemetry handler
`timescale 1ns/1ps
`default_nettype none
module tdh_top_test;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic        field_sign = 0, mag_scale = 1, spin_on = 0;
  logic [31:0] haddr = 0, hwdata = 0, d, e;
  logic [1:0]  htrans = 0;
  logic [5:0]  det_pulse = 0;
  wire  logic  hready, hreadyout, hresp, conv_start_ff, sector_pulse_ff;
  wire  logic  mem_wr_ff, mem_rd_valid, mem_rd_ready_ff, ser_data_ff;
  wire  logic  subcarrier_ff;
  wire  logic [31:0] hrdata;
  wire  logic [7:0]  conv_data, mem_wdata_ff, mem_rdata, cmd_out_ff;
  wire  logic [5:0]  amux_sel_ff;
  int fail_count = 0, cmp_count = 0, cyc = 0, wr_cnt = 0, pcnt = 0;
  int ph = 0, last = 0, gap = 0, prev_gap = 0, i, p0, p1;
  int rd_cnt = 0, sub_tog = 0;
  logic sub_prev = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  tdh_top #(.MET_CYC(50)) dut (.hclk(hclk), .hresetn(hresetn),
    .clk_en(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .det_pulse(det_pulse), .status_bits({33{3'b101}}),
    .field_sign(field_sign), .mag_scale(mag_scale), .conv_data(conv_data),
    .amux_sel_ff(amux_sel_ff), .conv_start_ff(conv_start_ff),
    .sector_pulse_ff(sector_pulse_ff), .mem_wr_ff(mem_wr_ff),
    .mem_wdata_ff(mem_wdata_ff), .mem_rd_valid(mem_rd_valid),
    .mem_rdata(mem_rdata), .mem_rd_ready_ff(mem_rd_ready_ff),
    .ser_data_ff(ser_data_ff), .subcarrier_ff(subcarrier_ff),
    .cmd_out_ff(cmd_out_ff));
  tdh_partner u_far (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start_ff), .mem_wr(mem_wr_ff),
    .mem_wdata(mem_wdata_ff), .mem_rd_ready(mem_rd_ready_ff),
    .conv_data(conv_data), .mem_rd_valid(mem_rd_valid),
    .mem_rdata(mem_rdata));
  // Spin of 8000 cycles, field crossing at phase zero
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc > 95000) begin
      fail_count++;
      report_and_stop;
    end
    if (spin_on) begin
      ph <= (ph == 7999) ? 0 : ph + 1;
      field_sign <= (ph < 4000);
    end
    if (mem_wr_ff === 1'b1) wr_cnt <= wr_cnt + 1;
    if (mem_rd_ready_ff === 1'b1) rd_cnt <= rd_cnt + 1;
    sub_prev <= subcarrier_ff;
    if (subcarrier_ff === ~sub_prev) sub_tog <= sub_tog + 1;
    if (sector_pulse_ff === 1'b1) begin
      pcnt <= pcnt + 1;
      gap <= cyc - last;
      prev_gap <= gap;
      last <= cyc;
    end
  end
  // ======================================================
  // Bus and checking tasks
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1; haddr <= a; hwrite <= wr; htrans <= 2'b10;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    d = hrdata;
  endtask
  task wait_frame;
    bus(1'b0, 32'h24, 32'h0);
    e = d;
    for (i = 0; i < 9000 && d === e; i++) bus(1'b0, 32'h24, 32'h0);
  endtask
  // ======================================================
  // Scenarios
  task t_reset;
    bus(1'b0, 32'h00, 32'h0); check(d, 32'h0);
    bus(1'b0, 32'h20, 32'h0); check(d, 32'hEB90);
    bus(1'b0, 32'h3C, 32'h0); check(d, 32'h0);
    check(cmd_out_ff, 8'h00);
  endtask
  task t_cmd;
    bus(1'b1, 32'h28, 32'hA5);
    repeat (2) @(posedge hclk);
    check(cmd_out_ff, 8'hA5);
  endtask
  task t_met;
    bus(1'b1, 32'h00, 32'h1);
    bus(1'b0, 32'h08, 32'h0); e = d;
    repeat (497) @(posedge hclk);
    bus(1'b0, 32'h08, 32'h0);
    check(d - e, 32'hA);
  endtask
  task t_acc;
    bus(1'b1, 32'h00, 32'h0);
    bus(1'b1, 32'h10, 32'h0);
    repeat (20) @(posedge hclk);
    for (i = 0; i < 5; i++) begin
      @(posedge hclk); det_pulse[0] <= 1'b1;
      repeat (4) @(posedge hclk); det_pulse[0] <= 1'b0;
      repeat (4) @(posedge hclk);
    end
    repeat (10) @(posedge hclk);
    bus(1'b0, 32'h1C, 32'h0); check(d, 32'h5);
    bus(1'b1, 32'h00, 32'h8);
    repeat (2000) @(posedge hclk);
    bus(1'b0, 32'h1C, 32'h0); check(d >= 6 && d <= 8, 1'b1);
    bus(1'b1, 32'h00, 32'h1);
    repeat (150) @(posedge hclk);
    bus(1'b0, 32'h1C, 32'h0); check(d, 32'h0);
  endtask
  task t_sample;
    bus(1'b1, 32'h00, 32'h5);
    for (i = 0; i < 5000 && conv_start_ff !== 1'b1; i++) @(posedge hclk);
    repeat (15) @(posedge hclk);
    bus(1'b0, 32'h18, 32'h0);
    check(d[8:0], 9'h15A);
  endtask
  task t_frame;
    wait_frame;
    p0 = rd_cnt;
    p1 = wr_cnt;
    wait_frame;
    // Sync bytes come from the framer, not the store
    check(rd_cnt - p0, 14);
    check(wr_cnt > p1, 1'b1);
    check(sub_tog > 0, 1'b1);
  endtask
  task t_sector;
    spin_on <= 1'b1;
    repeat (16000) @(posedge hclk);
    while (ph != 0) @(posedge hclk);
    p0 = pcnt;
    repeat (32000) @(posedge hclk);
    check(pcnt - p0, 16);
    check(gap, prev_gap);
    check(gap, 1000);
  endtask
  task report_and_stop;
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_cmd;
    t_met;
    t_acc;
    t_sample;
    t_frame;
    t_sector;
    report_and_stop;
  end
endmodule // tdh_top_test
bind tdh_top tdh_monitor u_mon (.hclk(hclk), .hresetn(hresetn),
  .hreadyout(hreadyout), .hresp(hresp), .amux_sel_ff(amux_sel_ff),
  .conv_start_ff(conv_start_ff), .sector_pulse_ff(sector_pulse_ff),
  .mem_wr_ff(mem_wr_ff), .mem_rd_valid(mem_rd_valid),
  .mem_rd_ready_ff(mem_rd_ready_ff));
`default_nettype wire
